/* cgf_gateway_fifo_ctrl.sv */
// How it works
// RULE1: gateway send flag set and data moved: set pointed object's request.
// RULE2: gateway send flag evaluated only after a data frame reception.
// RULE3: remote frame, remote enable clear: set own transmit request.
// RULE4: remote frame, remote enable set: set pointed object's request.
// RULE5: remote enable only for gateway transmit objects after remote reception.
// RULE6: software never sets remote enable on FIFO objects.
// RULE7: software points destination at source to get a source remote frame.
// RULE8: identifier copy set copies receiver identifier to transmitter.
// RULE9: identifier copy honoured only in normal gateway mode.
// RULE10: length code copy set copies receiver length code on data frames.
// RULE11: length code copy applied only in normal gateway mode.
// RULE12: fifo direction clear: base pointer advances on correct reception.
// RULE13: fifo direction set: base pointer advances on correct transmission.
// RULE14: fifo direction read from base object only; software sets all alike.
// RULE15: single transfer set clears object valid after a data transfer.
// RULE16: remote frames never clear object valid.
// RULE17: software keeps single transfer clear in FIFO objects.
// RULE18: single transmit try clears transmit request when transmission starts.
// RULE19: single transmit try frames are never retransmitted.
// RULE20: mode codes 000 std, 010 base, 011 slave, 100 normal, 101 shared.
// RULE21: in normal gateway mode the pointer names the destination object.
// RULE22: every object holds its own control bits, evaluated per event.
`timescale 1ns/1ps
`default_nettype none
module cgf_gateway_fifo_ctrl
    import cgf_pkg::*;
(
    input  wire logic             clk_sys,       // 10 MHz clock
    input  wire logic             rst_n,         // async reset, active low
    // axi4-lite slave
    input  wire logic [11:0]      s_axi_awaddr,  // write address
    input  wire logic             s_axi_awvalid, // write address valid
    output logic                  s_axi_awready, // write address ready
    input  wire logic [31:0]      s_axi_wdata,   // write data
    input  wire logic [3:0]       s_axi_wstrb,   // write strobes
    input  wire logic             s_axi_wvalid,  // write data valid
    output logic                  s_axi_wready,  // write data ready
    output logic [1:0]            s_axi_bresp,   // write response
    output logic                  s_axi_bvalid,  // write response valid
    input  wire logic             s_axi_bready,  // write response ready
    input  wire logic [11:0]      s_axi_araddr,  // read address
    input  wire logic             s_axi_arvalid, // read address valid
    output logic                  s_axi_arready, // read address ready
    output logic [31:0]           s_axi_rdata,   // read data
    output logic [1:0]            s_axi_rresp,   // read response
    output logic                  s_axi_rvalid,  // read data valid
    input  wire logic             s_axi_rready,  // read data ready
    // frame engine side
    input  wire cgf_evt_t         evt,           // one-cycle frame event
    input  wire logic [NUM_OBJ-1:0] objDir,      // direction bit per object
    output logic [NUM_OBJ-1:0]    txRequest,     // transmit request per object
    output logic [NUM_OBJ-1:0]    objValid,      // valid control per object
    output cgf_copy_t             copyCmd,       // identifier/length copy
    output logic                  copyStb        // copy command strobe
);
    ////////////////////////////////////////////////////////////////////////
    logic [15:0]      ctrl_r [NUM_OBJ];
    logic [2:0]       mode_r [NUM_OBJ];
    logic [PTR_W-1:0] ptr_r  [NUM_OBJ];
    logic [NUM_OBJ-1:0] txRequest_r;
    logic [NUM_OBJ-1:0] objValid_r;

    function automatic logic [1:0] regGroup(input logic [11:0] a);
        regGroup = a[8:7];
    endfunction : regGroup

    function automatic logic [PTR_W-1:0] regIdx(input logic [11:0] a);
        regIdx = a[6:2];
    endfunction : regIdx

    ////////////////////////////////////////////////////////////////////////
    // axi write path: address and data latched independently
    logic [11:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0]  wStrb_r;
    logic        awHave_r;
    logic        wHave_r;
    logic        bValid_r;
    logic [1:0]  bResp_r;
    logic        doWrite;

    assign s_axi_awready = !awHave_r && !bValid_r;
    assign s_axi_wready  = !wHave_r && !bValid_r;
    assign doWrite       = awHave_r && wHave_r && !bValid_r;
    assign s_axi_bvalid  = bValid_r;
    assign s_axi_bresp   = bResp_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            awHave_r <= 1'b0;
            awAddr_r <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHave_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
        end else if (doWrite) begin
            awHave_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wHave_r <= 1'b0;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHave_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
        end else if (doWrite) begin
            wHave_r <= 1'b0;
        end
    end

    logic wrOk;
    assign wrOk = (regGroup(awAddr_r) != 2'h3) && (awAddr_r[11:9] == 3'h0);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bValid_r <= 1'b0;
            bResp_r  <= 2'h0;
        end else if (doWrite) begin
            bValid_r <= 1'b1;
            bResp_r  <= wrOk ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            bValid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi read path
    logic        rValid_r;
    logic [31:0] rData_r;
    logic [1:0]  rResp_r;
    logic [PTR_W-1:0] ri;

    assign s_axi_arready = !rValid_r;
    assign s_axi_rvalid  = rValid_r;
    assign s_axi_rdata   = rData_r;
    assign s_axi_rresp   = rResp_r;
    assign ri            = regIdx(s_axi_araddr);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rValid_r <= 1'b0;
            rData_r  <= 32'h0000_0000;
            rResp_r  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rValid_r <= 1'b1;
            rResp_r  <= 2'h0;
            rData_r  <= 32'h0000_0000;
            if (s_axi_araddr[11:9] != 3'h0) begin
                rResp_r <= 2'h2;
            end else begin
                unique case (regGroup(s_axi_araddr))
                    2'h0: rData_r[15:0] <= ctrl_r[ri];
                    2'h1: rData_r[15:0] <= {5'h00, mode_r[ri], 3'h0,
                                            ptr_r[ri]};
                    2'h2: rData_r[2:0]  <= {objDir[ri], objValid_r[ri],
                                            txRequest_r[ri]};
                    2'h3: rResp_r       <= 2'h2;
                endcase
            end
        end else if (s_axi_rready) begin
            rValid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-object evaluation
    logic [NUM_OBJ-1:0] setOwn, setPtr, identifier_copy, lenC, clrV, clrT;

    genvar g;
    generate
        for (g = 0; g < NUM_OBJ; g++) begin : gObj
            cgf_evt_t ev;
            always_comb begin
                ev = evt;
                ev.rxDone  = evt.rxDone  && (evt.obj == PTR_W'(g));
                ev.txStart = evt.txStart && (evt.obj == PTR_W'(g));
                ev.txDone  = evt.txDone  && (evt.obj == PTR_W'(g));
            end
            cgf_obj_eval uEval (                              // [RULE22]
                .ctrl     (ctrl_r[g]),
                .mode     (mode_r[g]),
                .ptr      (ptr_r[g]),
                .dir      (objDir[g]),
                .evt      (ev),
                .setOwnTx (setOwn[g]),
                .setPtrTx (setPtr[g]),
                .idCopy   (identifier_copy[g]),
                .lenCopy  (lenC[g]),
                .clrValid (clrV[g]),
                .clrTx    (clrT[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // software register writes; the pointer also moves by fifo hardware
    logic [PTR_W-1:0] wi;
    logic [PTR_W-1:0] evObj;
    logic [PTR_W-1:0] baseObj;
    logic             fifoMember;
    logic             advance;

    assign wi      = regIdx(awAddr_r);
    assign evObj   = evt.obj;
    assign fifoMember = (mode_r[evObj] == MMC_FIFOSLV) ||
                        (mode_r[evObj] == MMC_FIFOBASE);
    // slaves point back at their base object
    assign baseObj = (mode_r[evObj] == MMC_FIFOBASE) ? evObj : ptr_r[evObj];

    always_comb begin
        advance = 1'b0;
        if (fifoMember && mode_r[baseObj] == MMC_FIFOBASE) begin
            if (!ctrl_r[baseObj][FD_POS]) begin // [RULE14]
                advance = evt.rxDone; // [RULE12]
            end else begin
                advance = evt.txDone; // [RULE13]
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_OBJ; i++) begin
                ctrl_r[i] <= CTRL_RST;
                mode_r[i] <= MODE_RST[MMC_LSB +: 3];
                ptr_r[i]  <= MODE_RST[PTR_LSB +: PTR_W];
            end
        end else begin
            if (doWrite && wrOk && regGroup(awAddr_r) == 2'h0) begin
                if (wStrb_r[1]) begin
                    ctrl_r[wi][15:8] <= wData_r[15:8] & CTRL_WMASK[15:8];
                end
            end
            if (doWrite && wrOk && regGroup(awAddr_r) == 2'h1) begin
                if (wStrb_r[0]) begin
                    ptr_r[wi] <= wData_r[PTR_LSB +: PTR_W];
                end
                if (wStrb_r[1]) begin
                    mode_r[wi] <= wData_r[MMC_LSB +: 3]; // [RULE20]
                end
            end
            // hardware update wins over a same-cycle software write
            if (advance) begin
                ptr_r[baseObj] <= ptr_r[baseObj] + 1'b1; // [RULE12] [RULE13]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit request: hardware sets win over clears; valid: hardware clear wins over software write
    logic [NUM_OBJ-1:0] setTx;
    always_comb begin
        setTx = setOwn;
        for (int i = 0; i < NUM_OBJ; i++) begin
            if (setPtr[i]) begin
                setTx[ptr_r[i]] = 1'b1; // [RULE1] [RULE4]
            end
        end
    end

    // software sets requests and valid through the status word
    logic [NUM_OBJ-1:0] swStat;
    always_comb begin
        swStat = '0;
        if (doWrite && wrOk && regGroup(awAddr_r) == 2'h2 && wStrb_r[0]) begin
            swStat[wi] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            txRequest_r <= '0;
        end else begin
            for (int i = 0; i < NUM_OBJ; i++) begin
                if (setTx[i]) begin
                    txRequest_r[i] <= 1'b1;
                end else if (clrT[i]) begin
                    txRequest_r[i] <= 1'b0; // [RULE18]
                end else if (evt.txDone && evt.obj == i[PTR_W-1:0]) begin
                    txRequest_r[i] <= 1'b0;
                end else if (swStat[i]) begin
                    txRequest_r[i] <= wData_r[ST_TRANSMIT_REQUEST_POS];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            objValid_r <= '0;
        end else begin
            for (int i = 0; i < NUM_OBJ; i++) begin
                if (clrV[i]) begin
                    objValid_r[i] <= 1'b0; // [RULE15]
                end else if (swStat[i]) begin
                    objValid_r[i] <= wData_r[ST_VAL_POS];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // copy command toward the object store, one cycle after the event
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            copyCmd <= '0;
            copyStb <= 1'b0;
        end else begin
            copyStb <= identifier_copy[evObj] || lenC[evObj];
            copyCmd.idCopy  <= identifier_copy[evObj];  // [RULE8]
            copyCmd.lenCopy <= lenC[evObj]; // [RULE10]
            copyCmd.src     <= evObj;
            copyCmd.dst     <= ptr_r[evObj];
        end
    end

    assign txRequest = txRequest_r;
    assign objValid  = objValid_r;

endmodule : cgf_gateway_fifo_ctrl
`default_nettype wire

/* cgf_pkg.sv */
package cgf_pkg;

    localparam int NUM_OBJ = 32;
    localparam int PTR_W   = 5;

    // register map (byte addresses, one word per object each)
    localparam logic [11:0] OFS_CTRL_BASE = 12'h000; // low control word
    localparam logic [11:0] OFS_MODE_BASE = 12'h080; // mode and pointer
    localparam logic [11:0] OFS_STAT_BASE = 12'h100; // live per-object state

    // control word field positions
    localparam int GATEWAY_DATA_FRAME_SEND_POS  = 8;
    localparam int SOURCE_REMOTE_REQUEST_ENABLE_POS = 9;
    localparam int IDC_POS   = 10;
    localparam int LENGTH_CODE_COPY_POS  = 11;
    localparam int FD_POS    = 13;
    localparam int SDT_POS   = 14;
    localparam int STT_POS   = 15;
    localparam logic [15:0] CTRL_WMASK = 16'hEF00;
    localparam logic [15:0] CTRL_RST   = 16'h0000;

    // mode word field positions
    localparam int PTR_LSB = 0;
    localparam int MMC_LSB = 8;
    localparam logic [15:0] MODE_RST = 16'h0000;

    // status word field positions
    localparam int ST_TRANSMIT_REQUEST_POS = 0;
    localparam int ST_VAL_POS  = 1;
    localparam int ST_DIR_POS  = 2;

    typedef enum logic [2:0] {
        MMC_STD      = 3'h0,
        MMC_FIFOBASE = 3'h2,
        MMC_FIFOSLV  = 3'h3,
        MMC_NGW      = 3'h4,
        MMC_SGW      = 3'h5
    } cgf_mode_t;

    // one completed (or started) frame event from the frame engine
    typedef struct packed {
        logic             rxDone;    // correct reception finished
        logic             txStart;   // transmission started
        logic             txDone;    // correct transmission finished
        logic             remote;    // frame was a remote frame
        logic [PTR_W-1:0] obj;       // message object involved
        logic             gwMoved;   // new data moved through gateway
    } cgf_evt_t;

    // copy commands toward the object store
    typedef struct packed {
        logic             idCopy;
        logic             lenCopy;
        logic [PTR_W-1:0] src;
        logic [PTR_W-1:0] dst;
    } cgf_copy_t;

endpackage : cgf_pkg

/* cgf_obj_eval.sv */
`timescale 1ns/1ps
`default_nettype none
module cgf_obj_eval
    import cgf_pkg::*;
(
    input  wire logic [15:0]      ctrl,      // object control word
    input  wire logic [2:0]       mode,      // object mode code
    input  wire logic [PTR_W-1:0] ptr,       // object pointer
    input  wire logic             dir,       // object direction bit
    input  wire cgf_evt_t         evt,       // frame event
    output logic                  setOwnTx,  // set own transmit request
    output logic                  setPtrTx,  // set pointed transmit request
    output logic                  idCopy,    // copy identifier
    output logic                  lenCopy,   // copy length code
    output logic                  clrValid,  // clear object valid
    output logic                  clrTx      // clear own transmit request
);
    logic gw;
    logic ngw;
    always_comb begin
        ngw = (mode == MMC_NGW);
        gw  = ngw || (mode == MMC_SGW);
        setOwnTx = 1'b0;
        setPtrTx = 1'b0;
        idCopy   = 1'b0;
        lenCopy  = 1'b0;
        clrValid = 1'b0;
        clrTx    = 1'b0;
        // data frame received on a gateway source
        if (evt.rxDone && !evt.remote && gw && evt.gwMoved) begin
            if (!dir && ctrl[GATEWAY_DATA_FRAME_SEND_POS]) begin // [RULE2]
                setPtrTx = 1'b1; // [RULE1] [RULE21]
            end
            idCopy  = ngw && ctrl[IDC_POS];   // [RULE8] [RULE9]
            lenCopy = ngw && ctrl[LENGTH_CODE_COPY_POS];  // [RULE10] [RULE11]
        end
        // remote frame received on a gateway transmit object
        if (evt.rxDone && evt.remote && gw && dir) begin // [RULE5]
            if (ctrl[SOURCE_REMOTE_REQUEST_ENABLE_POS]) begin
                setPtrTx = 1'b1; // [RULE4]
            end else begin
                setOwnTx = 1'b1; // [RULE3]
            end
            idCopy = ngw && ctrl[IDC_POS]; // [RULE8] [RULE9]
        end
        if ((evt.rxDone || evt.txDone) && !evt.remote && ctrl[SDT_POS]) begin
            clrValid = 1'b1; // [RULE15] [RULE16]
        end
        if (evt.txStart && ctrl[STT_POS]) begin
            clrTx = 1'b1; // [RULE18] [RULE19]
        end
    end
endmodule : cgf_obj_eval
`default_nettype wire

/* cgf_gateway_fifo_ctrl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module cgf_chk
    import cgf_pkg::*;
(
    input wire logic               clk_sys,       // clock
    input wire logic               rst_n,         // reset
    input wire logic               s_axi_bvalid,  // write resp valid
    input wire logic [1:0]         s_axi_bresp,   // write resp
    input wire logic               s_axi_bready,  // write resp ready
    input wire logic               s_axi_arvalid, // read addr valid
    input wire logic               s_axi_arready, // read addr ready
    input wire logic               s_axi_rvalid,  // read valid
    input wire logic [31:0]        s_axi_rdata,   // read data
    input wire logic               s_axi_rready,  // read ready
    input wire cgf_evt_t           evt,           // frame event
    input wire logic [NUM_OBJ-1:0] txRequest,     // requests
    input wire logic [NUM_OBJ-1:0] objValid,      // valid bits
    input wire cgf_copy_t          copyCmd,       // copy command
    input wire logic               copyStb        // copy strobe
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    a_copy_source: assert property (copyStb |-> $past(evt.rxDone)
        && copyCmd.src == $past(evt.obj))
        else $error("copy without matching reception");
    a_len_data_only: assert property (copyStb && copyCmd.lenCopy
        |-> !$past(evt.remote)) else $error("length copied on remote");
    a_tx_rise_cause: assert property (|(txRequest & ~$past(txRequest))
        |-> $past(evt.rxDone) || s_axi_bvalid || $past(s_axi_bvalid))
        else $error("request set without cause");
    a_tx_fall_cause: assert property (|($past(txRequest) & ~txRequest)
        |-> $past(evt.txStart) || $past(evt.txDone) || s_axi_bvalid
        || $past(s_axi_bvalid)) else $error("request cleared without cause");
    a_valid_fall_data: assert property (|($past(objValid) & ~objValid)
        |-> (($past(evt.rxDone) || $past(evt.txDone)) && !$past(evt.remote))
        || s_axi_bvalid || $past(s_axi_bvalid))
        else $error("valid cleared without data transfer");
    c_copy: cover property (copyStb && copyCmd.idCopy);
    c_tx_rise: cover property ($past(evt.rxDone) && |(txRequest & ~$past(txRequest)));
    c_valid_fall: cover property (|($past(objValid) & ~objValid));
endmodule : cgf_chk
bind cgf_gateway_fifo_ctrl cgf_chk u_chk (.*);
`default_nettype wire

/* cgf_fe_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cgf_fe_model
    import cgf_pkg::*;
(
    input  wire logic              clk_sys, // clock
    output var  cgf_evt_t          evt,     // frame event
    output var  logic [NUM_OBJ-1:0] objDir  // direction per object
);
    initial begin
        evt    = '0;
        objDir = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    // idle fields scramble so a stale object number never matches by luck
    task automatic frame(input logic [3:0] k, input logic [PTR_W-1:0] o,
                         input logic gw, input int gap);
        repeat (gap) @(posedge clk_sys);
        evt <= '{k[3], k[2], k[1], k[0], o, gw};
        @(posedge clk_sys);
        evt <= '{1'b0, 1'b0, 1'b0, ~k[0], ~o, ~gw};
    endtask : frame
    task automatic setDir(input int o, input logic d);
        @(posedge clk_sys);
        objDir[o] <= d;
    endtask : setDir
endmodule : cgf_fe_model
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cgf_pkg::*;
    localparam logic [3:0] EV_RX = 4'h8, EV_RXR = 4'h9, EV_ST = 4'h4;
    localparam logic [3:0] EV_DN = 4'h2;
    logic clk_sys, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, copyStb;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [NUM_OBJ-1:0] objDir, txRequest, objValid;
    cgf_evt_t evt;
    cgf_copy_t copyCmd, lastCopy;
    int failCount = 0;
    int nTests = 0;
    int nCopy = 0;
    cgf_gateway_fifo_ctrl uut (.*);
    cgf_fe_model u_fe (.clk_sys, .evt, .objDir);
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (copyStb) lastCopy <= copyCmd;
        if (copyStb && (copyCmd.idCopy || copyCmd.lenCopy)) nCopy <= nCopy + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            failCount++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic testDone();
        $display("mismatches %0d, checks %0d", failCount, nTests);
        if (failCount == 0 && nTests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : testDone
    task automatic hang();
        failCount++;
        $display("CHECK FAILED at %0t: bus answer missing", $time);
        testDone();
    endtask : hang
    task automatic axiWr(input logic [11:0] a, input logic [31:0] d);
        logic aw, w, b;
        b = 1'b0;
        @(posedge clk_sys);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (int i = 0; i < 40 && !b; i++) begin
            @(negedge clk_sys);
            aw = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge clk_sys);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
        end
        if (!b) hang();
    endtask : axiWr
    task automatic axiRd(input logic [11:0] a);
        logic ar, r;
        r = 1'b0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (int i = 0; i < 40 && !r; i++) begin
            @(negedge clk_sys);
            ar = s_axi_arready;
            r = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge clk_sys);
            if (ar) s_axi_arvalid <= 1'b0;
            if (r) s_axi_rready <= 1'b0;
        end
        if (!r) hang();
    endtask : axiRd
    task automatic ev(input logic [3:0] k, input logic [4:0] o, input logic gw);
        u_fe.frame(k, o, gw, 1);
        repeat (3) @(posedge clk_sys);
    endtask : ev
    ////////////////////////////////////////////////////////////////////////
    task automatic tRegs();
        axiRd(OFS_CTRL_BASE + 12'h004);
        check(rd, 32'h0000_0000);
        axiWr(OFS_CTRL_BASE + 12'h004, 32'hFFFF_FFFF);
        axiRd(OFS_CTRL_BASE + 12'h004);
        check(rd, 32'h0000_EF00);
        for (int i = 0; i < 6; i++) begin
            if (i == 1) continue;
            axiWr(OFS_MODE_BASE + 12'h004, {21'h0, i[2:0], 8'h07});
            axiRd(OFS_MODE_BASE + 12'h004);
            check(rd, {21'h0, i[2:0], 8'h07});
        end
        axiRd(12'h180);
        check({30'h0, resp}, 32'h0000_0002);
        axiWr(12'h180, 32'h0000_0001);
        check({30'h0, resp}, 32'h0000_0002);
    endtask : tRegs
    task automatic tGateway();
        axiWr(OFS_MODE_BASE + 12'h004, 32'h0000_0407);
        axiWr(OFS_CTRL_BASE + 12'h004, 32'h0000_0D00);
        ev(EV_RX, 5'd1, 1'b1);
        check({txRequest[7], txRequest[1]}, 32'h2);
        check(lastCopy, {1'b1, 1'b1, 5'd1, 5'd7});
        axiWr(OFS_STAT_BASE + 12'h01C, 32'h0);
        axiWr(OFS_CTRL_BASE + 12'h004, 32'h0000_0C00);
        ev(EV_RX, 5'd1, 1'b1);
        check(txRequest[7], 32'h0);
        axiWr(OFS_CTRL_BASE + 12'h004, 32'h0000_0100);
        u_fe.setDir(1, 1'b1);
        ev(EV_RX, 5'd1, 1'b1);
        check(txRequest[7], 32'h0);
    endtask : tGateway
    task automatic tShared();
        int n0;
        n0 = nCopy;
        axiWr(OFS_MODE_BASE + 12'h004, 32'h0000_0507);
        axiWr(OFS_CTRL_BASE + 12'h004, 32'h0000_0D00);
        u_fe.setDir(1, 1'b0);
        ev(EV_RX, 5'd1, 1'b1);
        check(txRequest[7], 32'h1);
        check(nCopy, n0);
    endtask : tShared
    task automatic tRemote();
        axiWr(OFS_MODE_BASE + 12'h004, 32'h0000_0407);
        axiWr(OFS_CTRL_BASE + 12'h004, 32'h0000_0000);
        axiWr(OFS_STAT_BASE + 12'h01C, 32'h0);
        u_fe.setDir(1, 1'b1);
        ev(EV_RXR, 5'd1, 1'b0);
        check({txRequest[7], txRequest[1]}, 32'h1);
        axiWr(OFS_STAT_BASE + 12'h004, 32'h0);
        axiWr(OFS_CTRL_BASE + 12'h004, 32'h0000_0200);
        ev(EV_RXR, 5'd1, 1'b0);
        check({txRequest[7], txRequest[1]}, 32'h2);
    endtask : tRemote
    task automatic tFifo();
        axiWr(OFS_MODE_BASE + 12'h010, 32'h0000_0204);
        for (int i = 5; i < 7; i++) axiWr(OFS_MODE_BASE + 12'(4 * i), 32'h0304);
        ev(EV_RX, 5'd4, 1'b0);
        axiRd(OFS_MODE_BASE + 12'h010);
        check(rd, 32'h0000_0205);
        ev(EV_DN, 5'd5, 1'b0);
        axiRd(OFS_MODE_BASE + 12'h010);
        check(rd, 32'h0000_0205);
        // same direction in every element, remote and single transfer off
        for (int i = 4; i < 7; i++) axiWr(OFS_CTRL_BASE + 12'(4 * i), 32'h2000);
        ev(EV_DN | 4'h1, 5'd5, 1'b0);
        axiRd(OFS_MODE_BASE + 12'h010);
        check(rd, 32'h0000_0206);
        ev(EV_RX, 5'd6, 1'b0);
        axiRd(OFS_MODE_BASE + 12'h010);
        check(rd, 32'h0000_0206);
    endtask : tFifo
    task automatic tSingle();
        axiWr(OFS_CTRL_BASE + 12'h008, 32'h0000_4000);
        axiWr(OFS_STAT_BASE + 12'h008, 32'h2);
        ev(EV_RXR, 5'd2, 1'b0);
        check(objValid[2], 32'h1);
        ev(EV_RX, 5'd2, 1'b0);
        check(objValid[2], 32'h0);
        axiWr(OFS_STAT_BASE + 12'h008, 32'h2);
        ev(EV_DN, 5'd2, 1'b0);
        check(objValid[2], 32'h0);
        axiWr(OFS_CTRL_BASE + 12'h00C, 32'h0000_8000);
        axiWr(OFS_STAT_BASE + 12'h00C, 32'h3);
        u_fe.frame(EV_ST, 5'd3, 1'b0, 5);
        repeat (6) @(posedge clk_sys);
        check({objValid[3], txRequest[3]}, 32'h2);
        axiWr(OFS_CTRL_BASE + 12'h00C, 32'h0);
        axiWr(OFS_STAT_BASE + 12'h00C, 32'h1);
        ev(EV_ST, 5'd3, 1'b0);
        check(txRequest[3], 32'h1);
        ev(EV_DN, 5'd3, 1'b0);
        check(txRequest[3], 32'h0);
    endtask : tSingle
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hF;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        tRegs();
        tGateway();
        tShared();
        tRemote();
        tFifo();
        tSingle();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        check(txRequest, 32'h0);
        axiRd(OFS_MODE_BASE + 12'h010);
        check(rd, 32'h0);
        testDone();
    end
endmodule : tb_top
`default_nettype wire
